// ### shared/qdac_defs.svh
// Constants for the quad converter two-wire command slave.
`ifndef QDAC_DEFS_SVH
`define QDAC_DEFS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define QDAC_CLK_PERIOD_NS    25
`define QDAC_FILT_NS          50
`define QDAC_FILT_CYC         ((`QDAC_FILT_NS + `QDAC_CLK_PERIOD_NS - 1) / `QDAC_CLK_PERIOD_NS)
`define QDAC_STRAP_SETTLE_NS  1000
`define QDAC_STRAP_SETTLE_CYC ((`QDAC_STRAP_SETTLE_NS + `QDAC_CLK_PERIOD_NS - 1) / `QDAC_CLK_PERIOD_NS)
// ----------------------------------------
// Frame layout
// ----------------------------------------
`define QDAC_BITS_PER_BYTE 4'h8
`define QDAC_DATA_BYTES    2'h3
`define QDAC_GLOBAL_ADDR   7'h73
`define QDAC_STRAP_BASE    3'h1
`define QDAC_CODE_RESET    16'h0000
// ----------------------------------------
// Command and channel codes
// ----------------------------------------
`define QDAC_CMD_WRITE      4'h0
`define QDAC_CMD_UPDATE     4'h1
`define QDAC_CMD_WR_UPD_ALL 4'h2
`define QDAC_CMD_WR_UPD     4'h3
`define QDAC_CMD_PD         4'h4
`define QDAC_CMD_PD_CHIP    4'h5
`define QDAC_CMD_REF_INT    4'h6
`define QDAC_CMD_REF_EXT    4'h7
`define QDAC_CMD_NOP        4'hF
`define QDAC_CHAN_ALL       4'hF
`endif

// ### shared/qdac_pkg.sv
// Types shared by the quad converter command slave.
package qdac_pkg;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_DATA, S_ACK, S_SKIP} qdac_state_t;
  typedef enum logic [1:0] {P_LO, P_HI, P_DONE} qdac_phase_t;
endpackage : qdac_pkg

// ### verilog/qdac_strap_sense.sv
// Three-state address strap sensing and slave address forming.
`timescale 1ns/1ps
`include "qdac_defs.svh"
module qdac_strap_sense #(
  parameter int SETTLE_CYC = `QDAC_STRAP_SETTLE_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [2:0] strap_in,
  output logic      [2:0] strap_out,
  output logic      [2:0] strap_oe,
  output logic      [6:0] slave_addr,
  output logic            addr_valid
);
  localparam int CW = $clog2(SETTLE_CYC + 1);
  qdac_pkg::qdac_phase_t phase_reg, phase_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [2:0]    s1_reg, s2_reg, lo_reg, lo_next, hi_reg, hi_next;
  logic [2:0]    out_reg, out_next, oe_reg, oe_next;
  logic [6:0]    addr_reg, addr_next;
  logic [1:0]    trit_w [3];
  logic [4:0]    idx_w;
  // ----------------------------------------
  // Pin states
  // ----------------------------------------
  // A strapped pin overrides the weak drive; an open pin follows it.
  for (genvar g = 0; g < 3; g++) begin : g_trit
    assign trit_w[g] = (!lo_reg[g] && !hi_reg[g]) ? 2'h0 : (lo_reg[g] && hi_reg[g]) ? 2'h2 : 2'h1;
  end
  assign idx_w = 5'(trit_w[2] * 9 + trit_w[1] * 3 + trit_w[0]);
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    phase_next = phase_reg;
    cnt_next   = cnt_reg;
    lo_next    = lo_reg;
    hi_next    = hi_reg;
    out_next   = out_reg;
    oe_next    = oe_reg;
    addr_next  = addr_reg;
    case (phase_reg)
      qdac_pkg::P_LO: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CW'(SETTLE_CYC)) begin
          lo_next    = s2_reg;
          cnt_next   = '0;
          out_next   = 3'h7;
          phase_next = qdac_pkg::P_HI;
        end
      end
      qdac_pkg::P_HI: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CW'(SETTLE_CYC)) begin
          hi_next    = s2_reg;
          oe_next    = 3'h0;
          out_next   = 3'h0;
          phase_next = qdac_pkg::P_DONE;
        end
      end
      qdac_pkg::P_DONE: begin
        addr_next = {3'(idx_w[4:2] + `QDAC_STRAP_BASE), 2'h0, idx_w[1:0]};
      end
      default: phase_next = qdac_pkg::P_LO;
    endcase
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_reg <= qdac_pkg::P_LO;
      cnt_reg   <= '0;
      s1_reg    <= 3'h0;
      s2_reg    <= 3'h0;
      lo_reg    <= 3'h0;
      hi_reg    <= 3'h0;
      out_reg   <= 3'h0;
      oe_reg    <= 3'h7;
      addr_reg  <= 7'h00;
    end else if (ce) begin
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
      s1_reg    <= strap_in;
      s2_reg    <= s1_reg;
      lo_reg    <= lo_next;
      hi_reg    <= hi_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
      addr_reg  <= addr_next;
    end
  end
  assign strap_out  = out_reg;
  assign strap_oe   = oe_reg;
  assign slave_addr = addr_reg;
  // The address is one cycle behind the phase; valid waits for it.
  logic valid_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      valid_reg <= 1'b0;
    end else if (ce) begin
      valid_reg <= (phase_reg == qdac_pkg::P_DONE);
    end
  end
  assign addr_valid = valid_reg;
endmodule : qdac_strap_sense

// ### verilog/qdac_cmd_slave.sv
// Two-wire write-only command slave for a quad voltage-output converter.
`timescale 1ns/1ps
`include "qdac_defs.svh"
module qdac_cmd_slave #(
  parameter int STRAP_SETTLE_CYC = `QDAC_STRAP_SETTLE_CYC,
  parameter int FILT_CYC         = `QDAC_FILT_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        addr_strap_bit0_in,
  output logic             addr_strap_bit0_out,
  output logic             addr_strap_bit0_oe,
  input  wire logic        addr_strap_bit1_in,
  output logic             addr_strap_bit1_out,
  output logic             addr_strap_bit1_oe,
  input  wire logic        addr_strap_bit2_in,
  output logic             addr_strap_bit2_out,
  output logic             addr_strap_bit2_oe,
  output logic [63:0]      input_words,
  output logic [63:0]      dac_words,
  output logic [3:0]       chan_pd,
  output logic             ref_ext_sel,
  output logic             ref_pd,
  output logic             cmd_strobe
);
  localparam int FW = $clog2(FILT_CYC + 1);
  logic [2:0] strap_out_w, strap_oe_w;
  logic [6:0] slave_addr_w;
  logic       addr_valid_w;
  // ----------------------------------------
  // Address straps
  // ----------------------------------------
  qdac_strap_sense #(.SETTLE_CYC(STRAP_SETTLE_CYC)) u_strap (
    .mclk       (mclk),
    .rst        (rst),
    .ce         (ce),
    .strap_in   ({addr_strap_bit2_in, addr_strap_bit1_in, addr_strap_bit0_in}),
    .strap_out  (strap_out_w),
    .strap_oe   (strap_oe_w),
    .slave_addr (slave_addr_w),
    .addr_valid (addr_valid_w)
  );
  assign {addr_strap_bit2_out, addr_strap_bit1_out, addr_strap_bit0_out} = strap_out_w;
  assign {addr_strap_bit2_oe, addr_strap_bit1_oe, addr_strap_bit0_oe}    = strap_oe_w;
  // ----------------------------------------
  // Line synchronisers and glitch filters
  // ----------------------------------------
  // Index 1 is the clock line, index 0 the data line.
  logic [1:0]    raw_w, s1_reg, s2_reg, flt_reg, flt_next, fd_reg;
  logic [FW-1:0] fcnt_reg [2];
  logic [FW-1:0] fcnt_next [2];
  assign raw_w = {scl_in, sda_in};
  for (genvar g = 0; g < 2; g++) begin : g_line
    always_comb begin
      flt_next[g]  = flt_reg[g];
      fcnt_next[g] = '0;
      if (s2_reg[g] != flt_reg[g]) begin
        fcnt_next[g] = fcnt_reg[g] + 1'b1;
        if (fcnt_reg[g] == FW'(FILT_CYC - 1)) begin
          flt_next[g]  = s2_reg[g];
          fcnt_next[g] = '0;
        end
      end
    end
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        s1_reg[g]   <= 1'b1;
        s2_reg[g]   <= 1'b1;
        flt_reg[g]  <= 1'b1;
        fd_reg[g]   <= 1'b1;
        fcnt_reg[g] <= '0;
      end else if (ce) begin
        s1_reg[g]   <= raw_w[g];
        s2_reg[g]   <= s1_reg[g];
        flt_reg[g]  <= flt_next[g];
        fd_reg[g]   <= flt_reg[g];
        fcnt_reg[g] <= fcnt_next[g];
      end
    end
  end
  logic rise_w, fall_w, start_w, stop_w, sda_f_w;
  assign sda_f_w = flt_reg[0];
  assign rise_w  = ce && flt_reg[1] && !fd_reg[1];
  assign fall_w  = ce && !flt_reg[1] && fd_reg[1];
  assign start_w = ce && flt_reg[1] && fd_reg[1] && fd_reg[0] && !flt_reg[0];
  assign stop_w  = ce && flt_reg[1] && fd_reg[1] && !fd_reg[0] && flt_reg[0];
  // ----------------------------------------
  // Byte engine
  // ----------------------------------------
  qdac_pkg::qdac_state_t st_reg, st_next;
  logic [3:0]  bit_reg, bit_next;
  logic [1:0]  byte_reg, byte_next;
  logic [7:0]  sh_reg, sh_next;
  logic [23:0] word_reg, word_next;
  logic        ack_reg, ack_next, oe_reg, oe_next, go_reg, go_next, addr_hit_w;
  assign addr_hit_w = addr_valid_w && (sh_reg[7:1] == slave_addr_w || sh_reg[7:1] == `QDAC_GLOBAL_ADDR);
  always_comb begin
    st_next   = st_reg;
    bit_next  = bit_reg;
    byte_next = byte_reg;
    sh_next   = sh_reg;
    word_next = word_reg;
    ack_next  = ack_reg;
    oe_next   = oe_reg;
    go_next   = 1'b0;
    if (stop_w) begin
      st_next = qdac_pkg::S_IDLE;
      oe_next = 1'b0;
    end else if (start_w) begin
      st_next  = qdac_pkg::S_ADDR;
      bit_next = 4'h0;
      oe_next  = 1'b0;
    end else begin
      case (st_reg)
        qdac_pkg::S_ADDR, qdac_pkg::S_DATA: begin
          if (rise_w) begin
            sh_next  = {sh_reg[6:0], sda_f_w};
            bit_next = bit_reg + 4'h1;
          end
          if (fall_w && bit_reg == `QDAC_BITS_PER_BYTE) begin
            bit_next = 4'h0;
            st_next  = qdac_pkg::S_ACK;
            if (st_reg == qdac_pkg::S_ADDR) begin
              ack_next  = addr_hit_w && !sh_reg[0];
              byte_next = 2'h0;
            end else begin
              ack_next = (byte_reg != `QDAC_DATA_BYTES);
              if (ack_next) begin
                byte_next = byte_reg + 2'h1;
                word_next = {word_reg[15:0], sh_reg};
              end
            end
            oe_next = ack_next;
          end
        end
        qdac_pkg::S_ACK: begin
          // Released only on the falling edge, so the line is stable all high time.
          if (fall_w) begin
            oe_next = 1'b0;
            st_next = ack_reg ? qdac_pkg::S_DATA : qdac_pkg::S_SKIP;
            go_next = ack_reg && (byte_reg == `QDAC_DATA_BYTES);
          end
        end
        qdac_pkg::S_IDLE, qdac_pkg::S_SKIP: st_next = st_reg;
        default: st_next = qdac_pkg::S_IDLE;
      endcase
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg   <= qdac_pkg::S_IDLE;
      bit_reg  <= 4'h0;
      byte_reg <= 2'h0;
      sh_reg   <= 8'h00;
      word_reg <= 24'h000000;
      ack_reg  <= 1'b0;
      oe_reg   <= 1'b0;
      go_reg   <= 1'b0;
    end else if (ce) begin
      st_reg   <= st_next;
      bit_reg  <= bit_next;
      byte_reg <= byte_next;
      sh_reg   <= sh_next;
      word_reg <= word_next;
      ack_reg  <= ack_next;
      oe_reg   <= oe_next;
      go_reg   <= go_next;
    end
  end
  assign sda_out    = 1'b0;
  assign sda_oe     = oe_reg;
  assign cmd_strobe = go_reg;
  // ----------------------------------------
  // Command execution
  // ----------------------------------------
  logic [3:0]  cmd_w, chan_w, sel_w, wr_w, up_w, pd_w, pd_reg, pd_next;
  logic [15:0] code_w;
  logic [15:0] in_reg [4];
  logic [15:0] in_next [4];
  logic [15:0] dac_reg [4];
  logic [15:0] dac_next [4];
  logic        go_w, ext_reg, ext_next, rpd_reg, rpd_next, chip_reg, chip_next;
  assign cmd_w  = word_reg[23:20];
  assign chan_w = word_reg[19:16];
  assign code_w = word_reg[15:0];
  assign go_w   = ce && go_reg;
  for (genvar c = 0; c < 4; c++) begin : g_chan
    assign sel_w[c] = (chan_w == 4'(c)) || (chan_w == `QDAC_CHAN_ALL);
    assign wr_w[c]  = go_w && sel_w[c] && (cmd_w == `QDAC_CMD_WRITE || cmd_w == `QDAC_CMD_WR_UPD
                      || cmd_w == `QDAC_CMD_WR_UPD_ALL);
    assign up_w[c]  = go_w && ((sel_w[c] && (cmd_w == `QDAC_CMD_UPDATE || cmd_w == `QDAC_CMD_WR_UPD))
                      || cmd_w == `QDAC_CMD_WR_UPD_ALL);
    assign pd_w[c]  = go_w && ((sel_w[c] && cmd_w == `QDAC_CMD_PD) || cmd_w == `QDAC_CMD_PD_CHIP);
    always_comb begin
      in_next[c]  = wr_w[c] ? code_w : in_reg[c];
      dac_next[c] = up_w[c] ? in_next[c] : dac_reg[c];
      pd_next[c]  = up_w[c] ? 1'b0 : (pd_w[c] ? 1'b1 : pd_reg[c]);
    end
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        in_reg[c]  <= `QDAC_CODE_RESET;
        dac_reg[c] <= `QDAC_CODE_RESET;
        pd_reg[c]  <= 1'b0;
      end else if (ce) begin
        in_reg[c]  <= in_next[c];
        dac_reg[c] <= dac_next[c];
        pd_reg[c]  <= pd_next[c];
      end
    end
    assign input_words[16*c +: 16] = in_reg[c];
    assign dac_words[16*c +: 16]   = dac_reg[c];
  end
  // A reference shut by the chip power-down wakes with any update; one shut by the
  // external select wakes only on an explicit internal select.
  always_comb begin
    ext_next  = ext_reg;
    rpd_next  = rpd_reg;
    chip_next = chip_reg;
    if (go_w) begin
      case (cmd_w)
        `QDAC_CMD_REF_INT: begin
          ext_next  = 1'b0;
          rpd_next  = 1'b0;
          chip_next = 1'b0;
        end
        `QDAC_CMD_REF_EXT: begin
          ext_next  = 1'b1;
          rpd_next  = 1'b1;
          chip_next = 1'b0;
        end
        `QDAC_CMD_PD_CHIP: begin
          rpd_next  = 1'b1;
          chip_next = !ext_reg;
        end
        default: ext_next = ext_reg;
      endcase
      if (|up_w && chip_reg) begin
        rpd_next  = 1'b0;
        chip_next = 1'b0;
      end
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_reg  <= 1'b0;
      rpd_reg  <= 1'b0;
      chip_reg <= 1'b0;
    end else if (ce) begin
      ext_reg  <= ext_next;
      rpd_reg  <= rpd_next;
      chip_reg <= chip_next;
    end
  end
  assign chan_pd     = pd_reg;
  assign ref_ext_sel = ext_reg;
  assign ref_pd      = rpd_reg;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic byte_end_w;
  assign byte_end_w = fall_w && bit_reg == `QDAC_BITS_PER_BYTE;
  ack_on_fall_a: assert property ($rose(oe_reg) |-> $past(fall_w))
    else $error("Acknowledge drive began away from a clock fall.");
  ack_hold_a: assert property ((oe_reg && flt_reg[1]) |=> oe_reg)
    else $error("Acknowledge released while the clock was high.");
  read_ignore_a: assert property ((st_reg == qdac_pkg::S_ADDR && byte_end_w && sh_reg[0]) |=> !oe_reg)
    else $error("Read address was acknowledged.");
  addr_ack_a: assert property ((st_reg == qdac_pkg::S_ADDR && byte_end_w && addr_hit_w && !sh_reg[0])
    |=> oe_reg && st_reg == qdac_pkg::S_ACK)
    else $error("Matching write address not acknowledged.");
  extra_nack_a: assert property ((st_reg == qdac_pkg::S_DATA && byte_end_w && byte_reg == `QDAC_DATA_BYTES)
    |=> !oe_reg ##1 (!oe_reg))
    else $error("Fourth data byte was acknowledged.");
  exec_count_a: assert property ($rose(go_reg) |-> $past(byte_reg) == `QDAC_DATA_BYTES && $past(ack_reg))
    else $error("Command ran before three data bytes.");
  start_seen_a: assert property (start_w && !stop_w |=> st_reg == qdac_pkg::S_ADDR && bit_reg == 4'h0)
    else $error("Start did not open an address byte.");
  stop_free_a: assert property (stop_w |=> st_reg == qdac_pkg::S_IDLE && !oe_reg)
    else $error("Stop did not free the bus.");
  ext_ref_a: assert property ((go_w && cmd_w == `QDAC_CMD_REF_EXT) |=> ext_reg && rpd_reg)
    else $error("External reference select failed.");
  int_ref_a: assert property ((go_w && cmd_w == `QDAC_CMD_REF_INT) |=> !ext_reg && !rpd_reg)
    else $error("Internal reference select failed.");
  ext_cause_a: assert property ($rose(ext_reg) |-> $past(go_w && cmd_w == `QDAC_CMD_REF_EXT))
    else $error("External reference selected without its command.");
  chip_pd_a: assert property ((go_w && cmd_w == `QDAC_CMD_PD_CHIP) |=> pd_reg == 4'hF && rpd_reg)
    else $error("Chip power-down incomplete.");
  upd_a: assert property ((go_w && cmd_w == `QDAC_CMD_WR_UPD && chan_w == 4'h0) |=> dac_reg[0] == $past(code_w)
    && !pd_reg[0])
    else $error("Write and update of channel A failed.");
  write_cov: cover property (go_w && cmd_w == `QDAC_CMD_WR_UPD);
  read_cov: cover property (st_reg == qdac_pkg::S_ADDR && byte_end_w && sh_reg[0]);
  global_cov: cover property (st_reg == qdac_pkg::S_ADDR && byte_end_w && sh_reg[7:1] == `QDAC_GLOBAL_ADDR);
  extra_cov: cover property (st_reg == qdac_pkg::S_DATA && byte_end_w && byte_reg == `QDAC_DATA_BYTES);
endmodule : qdac_cmd_slave

// ### testbench/qdac_bus_master.sv
// Two-wire bus master model that drives the command slave from the far side.
`timescale 1ns/1ps
module qdac_bus_master #(
  parameter int HALF_CYC = 8
) (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // ----------------------------------------
  // Bus phases
  // ----------------------------------------
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  task automatic wait_c(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_c
  // Data only moves two cycles after the clock falls, so no false start or stop is seen.
  task automatic pulse();
    wait_c(HALF_CYC);
    scl = 1'h1;
    wait_c(HALF_CYC);
    scl = 1'h0;
    wait_c(2);
  endtask : pulse
  task automatic start_c();
    sda_low = 1'h0;
    wait_c(HALF_CYC);
    scl = 1'h1;
    wait_c(HALF_CYC);
    sda_low = 1'h1;
    wait_c(HALF_CYC);
    scl = 1'h0;
    wait_c(2);
  endtask : start_c
  task automatic stop_c();
    sda_low = 1'h1;
    wait_c(HALF_CYC);
    scl = 1'h1;
    wait_c(HALF_CYC);
    sda_low = 1'h0;
    wait_c(HALF_CYC);
  endtask : stop_c
  task automatic byte_tx(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      pulse();
    end
    sda_low = 1'h0;
    wait_c(HALF_CYC);
    scl = 1'h1;
    wait_c(1);
    ack = ~sda_line;
    wait_c(HALF_CYC - 1);
    ack = ack & ~sda_line;
    scl = 1'h0;
    wait_c(2);
  endtask : byte_tx
endmodule : qdac_bus_master

// ### testbench/qdac_cmd_slave_bench.sv
// Self-checking bench for the two-wire command slave.
`timescale 1ns/1ps
module qdac_cmd_slave_bench;
  // ----------------------------------------
  // Pins and instances
  // ----------------------------------------
  logic        mclk, rst, ce, scl, m_low, sda_out, sda_oe, ref_ext_sel, ref_pd, cmd_strobe;
  logic [2:0]  s_in, s_out, s_oe;
  logic [1:0]  strap_sel [3];
  logic [63:0] input_words, dac_words, exp_in, exp_dac;
  logic [3:0]  chan_pd;
  logic [6:0]  my_addr;
  int          mismatches, checks, strobes;
  wire         sda_line = ~((sda_oe & ~sda_out) | m_low);
  // A tied strap wins over the device drive; an open one floats high when undriven.
  always_comb for (int k = 0; k < 3; k++) s_in[k] = strap_sel[k] == 2'h1 ? ~s_oe[k] | s_out[k] : strap_sel[k][1];
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) if (cmd_strobe === 1'h1) strobes <= strobes + 1;
  qdac_cmd_slave #(.STRAP_SETTLE_CYC(3), .FILT_CYC(2)) qdac_cmd_slave_inst (
    .mclk(mclk), .rst(rst), .ce(ce), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_bit0_in(s_in[0]), .addr_strap_bit0_out(s_out[0]), .addr_strap_bit0_oe(s_oe[0]),
    .addr_strap_bit1_in(s_in[1]), .addr_strap_bit1_out(s_out[1]), .addr_strap_bit1_oe(s_oe[1]),
    .addr_strap_bit2_in(s_in[2]), .addr_strap_bit2_out(s_out[2]), .addr_strap_bit2_oe(s_oe[2]),
    .input_words(input_words), .dac_words(dac_words), .chan_pd(chan_pd), .ref_ext_sel(ref_ext_sel),
    .ref_pd(ref_pd), .cmd_strobe(cmd_strobe));
  qdac_bus_master qdac_bus_master_inst (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(m_low));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_state(input logic [3:0] pd, input logic ext, input logic rpd);
    chk("chan_pd", pd, chan_pd);
    chk("ref_ext_sel", ext, ref_ext_sel);
    chk("ref_pd", rpd, ref_pd);
    chk("input_words", exp_in, input_words);
    chk("dac_words", exp_dac, dac_words);
  endtask : chk_state
  // Straps are sensed only once after reset, so a new address needs a new reset.
  task automatic do_reset(input logic [5:0] st);
    strap_sel[2] = st[5:4];
    strap_sel[1] = st[3:2];
    strap_sel[0] = st[1:0];
    rst = 1'h1;
    repeat (12) @(negedge mclk);
    rst = 1'h0;
    repeat (40) @(negedge mclk);
  endtask : do_reset
  task automatic frame(input logic [6:0] a, input logic rd, input int n, input logic [31:0] d,
                       output logic [4:0] acks);
    logic ack;
    acks = 5'h00;
    qdac_bus_master_inst.start_c();
    qdac_bus_master_inst.byte_tx({a, rd}, ack);
    acks[0] = ack;
    for (int i = 1; i <= n; i++) begin
      qdac_bus_master_inst.byte_tx(d[39-8*i -: 8], ack);
      acks[i] = ack;
    end
    qdac_bus_master_inst.stop_c();
    repeat (4) @(negedge mclk);
  endtask : frame
  task automatic cmd(input logic [6:0] a, input logic [3:0] c, input logic [3:0] ch, input logic [15:0] v);
    logic [4:0] acks;
    int         s0;
    s0 = strobes;
    frame(a, 1'h0, 3, {c, ch, v, 8'h00}, acks);
    chk("command acks", 5'h0F, acks);
    chk("command strobes", s0 + 1, strobes);
  endtask : cmd
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_address();
    logic [4:0] acks;
    logic [6:0] adr [4] = '{7'h10, 7'h41, 7'h72, 7'h43};
    logic [5:0] st [4] = '{6'h00, 6'h15, 6'h2A, 6'h18};
    for (int k = 0; k < 4; k++) begin
      do_reset(st[k]);
      frame(adr[k], 1'h0, 0, 32'h0, acks);
      chk("own address ack", 1, acks[0]);
      frame(adr[k] ^ 7'h04, 1'h0, 0, 32'h0, acks);
      chk("other address ack", 0, acks[0]);
      frame(adr[k], 1'h1, 0, 32'h0, acks);
      chk("read address ack", 0, acks[0]);
      frame(7'h73, 1'h0, 0, 32'h0, acks);
      chk("global address ack", 1, acks[0]);
    end
    my_addr = adr[3];
    chk_state(4'h0, 1'h0, 1'h0);
  endtask : t_address
  task automatic t_write();
    cmd(my_addr, 4'h0, 4'h2, 16'hA5C3);
    exp_in[47:32] = 16'hA5C3;
    chk_state(4'h0, 1'h0, 1'h0);
    cmd(my_addr, 4'h1, 4'h2, 16'h0000);
    exp_dac[47:32] = 16'hA5C3;
    chk_state(4'h0, 1'h0, 1'h0);
    cmd(my_addr, 4'h3, 4'h3, 16'h1234);
    exp_in[63:48] = 16'h1234;
    exp_dac[63:48] = 16'h1234;
    chk_state(4'h0, 1'h0, 1'h0);
    cmd(my_addr, 4'h2, 4'h0, 16'h0F0F);
    exp_in[15:0] = 16'h0F0F;
    exp_dac = exp_in;
    chk_state(4'h0, 1'h0, 1'h0);
    cmd(7'h73, 4'h0, 4'h1, 16'h5AA5);
    exp_in[31:16] = 16'h5AA5;
    chk_state(4'h0, 1'h0, 1'h0);
  endtask : t_write
  task automatic t_power();
    cmd(my_addr, 4'h4, 4'hF, 16'h0000);
    chk_state(4'hF, 1'h0, 1'h0);
    cmd(my_addr, 4'h1, 4'h1, 16'h0000);
    exp_dac[31:16] = exp_in[31:16];
    chk_state(4'hD, 1'h0, 1'h0);
    cmd(my_addr, 4'h5, 4'h0, 16'h0000);
    chk_state(4'hF, 1'h0, 1'h1);
    cmd(my_addr, 4'h1, 4'hF, 16'h0000);
    chk_state(4'h0, 1'h0, 1'h0);
    cmd(my_addr, 4'h7, 4'h0, 16'h0000);
    chk_state(4'h0, 1'h1, 1'h1);
    cmd(my_addr, 4'h1, 4'hF, 16'h0000);
    chk_state(4'h0, 1'h1, 1'h1);
    cmd(my_addr, 4'h6, 4'h0, 16'h0000);
    chk_state(4'h0, 1'h0, 1'h0);
  endtask : t_power
  task automatic t_refuse();
    logic [4:0] acks;
    int         s0;
    cmd(my_addr, 4'hF, 4'h0, 16'hFFFF);
    chk_state(4'h0, 1'h0, 1'h0);
    s0 = strobes;
    frame(my_addr, 1'h0, 2, {8'h30, 16'hBEEF, 8'h00}, acks);
    chk("short frame acks", 5'h07, acks);
    chk("short frame strobes", s0, strobes);
    frame(my_addr, 1'h0, 4, {8'h30, 16'hBEEF, 8'h77}, acks);
    chk("long frame acks", 5'h0F, acks);
    chk("long frame strobes", s0 + 1, strobes);
    // A low enable freezes the slave, so a full frame must pass unanswered.
    ce = 1'h0;
    frame(my_addr, 1'h0, 3, {8'h3F, 16'h0000, 8'h00}, acks);
    ce = 1'h1;
    chk("frozen frame acks", 5'h00, acks);
    chk("frozen frame strobes", s0 + 1, strobes);
    exp_in[15:0] = 16'hBEEF;
    exp_dac[15:0] = 16'hBEEF;
    chk_state(4'h0, 1'h0, 1'h0);
  endtask : t_refuse
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    rst = 1'h1;
    ce = 1'h1;
    mismatches = 0;
    checks = 0;
    strobes = 0;
    exp_in = 64'h0;
    exp_dac = 64'h0;
    my_addr = 7'h10;
    strap_sel = '{2'h0, 2'h0, 2'h0};
    t_address();
    t_write();
    t_power();
    t_refuse();
    tally_and_finish();
  end
endmodule : qdac_cmd_slave_bench
